// file: bench/sdr_host.sv
`timescale 1ns/1ns
`default_nettype none
// ------------------------------
// Host side of the register port
// ------------------------------
module sdr_host (
	input wire logic clk_i,
	output logic wr_en_o,
	output logic [1:0] wr_sel_o,
	output logic [7:0] wr_data_o,
	output logic [1:0] rd_sel_o
);
	initial begin
		wr_en_o = 1'b0;
		wr_sel_o = 2'h0;
		wr_data_o = 8'h00;
		rd_sel_o = 2'h0;
	end
	// One write per edge, back to back allowed
	task automatic wr(input logic [1:0] sel, input logic [7:0] data);
		@(posedge clk_i);
		wr_en_o <= 1'b1;
		wr_sel_o <= sel;
		wr_data_o <= data;
	endtask : wr
	// Strobe dropped, data scrambled so stale bytes never look valid
	task automatic idle();
		@(posedge clk_i);
		wr_en_o <= 1'b0;
		wr_data_o <= ~wr_data_o;
	endtask : idle
	task automatic rd(input logic [1:0] sel);
		@(posedge clk_i);
		rd_sel_o <= sel;
	endtask : rd
endmodule : sdr_host
`default_nettype wire

// file: bench/sdr_top_tb.sv
`timescale 1ns/1ns
`default_nettype none
// ------------------------------
// Four channel control bench
// ------------------------------
module sdr_top_tb;
	logic clk_i, srst_i, ce_i, standby, wr_en;
	logic [1:0] wr_sel, rd_sel;
	logic [7:0] wr_data, rd_data;
	logic [19:0] codes;
	logic [3:0] pins, en_o, ss_o, slew_o, freq_o, ph_o;
	logic [79:0] vout, dac_o, ref_o;
	logic [7:0] mode_o;
	logic [3:0] freq_v;
	int bad_count = 0;
	int compares = 0;
	int mdl [4];
	int n;
	logic [31:0] seed = 32'hdbf0ae46;
	sdr_host host (.clk_i(clk_i), .wr_en_o(wr_en), .wr_sel_o(wr_sel), .wr_data_o(wr_data),
		.rd_sel_o(rd_sel));
	sdr_top uut (.clk_i(clk_i), .srst_i(srst_i), .ce_i(ce_i), .wr_en_i(wr_en),
		.wr_sel_i(wr_sel), .wr_data_i(wr_data), .rd_sel_i(rd_sel), .rd_data_o(rd_data),
		.reference_dac_code_i(codes), .step_down_enable_pin_i(pins), .standby_i(standby),
		.vout_uv_i(vout), .enabled_o(en_o), .soft_start_o(ss_o), .mode_o(mode_o),
		.slew_fast_o(slew_o), .freq_low_o(freq_o), .phase2_o(ph_o), .dac_uv_o(dac_o),
		.ref_uv_o(ref_o));
	// Termination variant copy, only its frequency select is watched
	sdr_top #(.TERMINATION_VARIANT(1'b1)) uut_var (.clk_i(clk_i), .srst_i(srst_i), .ce_i(ce_i),
		.wr_en_i(wr_en), .wr_sel_i(wr_sel), .wr_data_i(wr_data), .rd_sel_i(rd_sel),
		.rd_data_o(), .reference_dac_code_i(codes), .step_down_enable_pin_i(pins),
		.standby_i(standby), .vout_uv_i(vout), .enabled_o(), .soft_start_o(), .mode_o(),
		.slew_fast_o(), .freq_low_o(freq_v), .phase2_o(), .dac_uv_o(), .ref_uv_o());
	initial begin
		clk_i = 1'b0;
		forever #4 clk_i = ~clk_i;
	end
	function automatic logic [31:0] xs(input logic [31:0] x);
		x = x ^ (x << 13);
		x = x ^ (x >> 17);
		x = x ^ (x << 5);
		return x;
	endfunction : xs
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		compares++;
		if (g !== e) begin
			bad_count++;
			$display("unexpected %s expected %0h seen %0h", nm, e, g);
		end
	endtask : chk
	task automatic conclude();
		$display("compares %0d bad_count %0d", compares, bad_count);
		if (bad_count == 0 && compares > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : conclude
	task automatic tick(input int k);
		repeat (k) @(posedge clk_i);
		#1;
	endtask : tick
	// Ramp to about 450mV takes some 70000 cycles
	initial begin
		#(8 * 95000);
		bad_count++;
		conclude();
	end
	initial begin
		srst_i = 1'b1;
		ce_i = 1'b1;
		standby = 1'b0;
		pins = 4'h0;
		codes = {4{5'h19}};
		vout = {4{20'd500000}};
		repeat (16) @(posedge clk_i);
		srst_i <= 1'b0;
		tick(2);
		for (int g = 0; g < 4; g++) begin
			host.rd(g[1:0]);
			tick(1);
			chk("ctrl reset", 0, rd_data);
			chk("dac reset", 725000, dac_o[g*20+:20]);
		end
		chk("enabled reset", 0, en_o);
		chk("freq variant reset", 1, freq_v);
		$display("test reset done");
		// a keeps in standby, c by pin only, d waits for low output
		for (int g = 0; g < 4; g++) begin
			seed = xs(seed);
			mdl[g] = ((g != 2) << 7) | (((g + 1) % 4) << 5) | ((g == 3) << 4) | ((g == 0) << 1)
				| (seed & 32'hd);
			host.wr(g[1:0], mdl[g][7:0]);
		end
		host.idle();
		codes <= {5'd3, 5'd2, 5'd1, 5'd0};
		tick(3);
		for (int g = 0; g < 4; g++) begin
			host.rd(g[1:0]);
			tick(1);
			chk("ctrl readback", mdl[g], rd_data);
			chk("slew", mdl[g][0], slew_o[g]);
			chk("freq", mdl[g][2], freq_o[g]);
			chk("freq variant", (g == 0) ^ mdl[g][2], freq_v[g]);
			chk("phase", mdl[g][3], ph_o[g]);
			chk("enabled", g < 2, en_o[g]);
			chk("soft", g < 2, ss_o[g]);
			chk("soft mode", 0, mode_o[g*2+:2]);
		end
		chk("dac not stepped", 1, dac_o[19:0] > 20'd600000);
		@(posedge clk_i);
		pins <= 4'h4;
		vout[79:60] <= 20'd100000;
		tick(4);
		chk("enabled late", 4'hf, en_o);
		$display("test enable done");
		n = 0;
		while (ss_o !== 4'h0 && n < 90000) begin
			tick(1);
			n++;
		end
		chk("ramp finished", 0, ss_o);
		tick(2);
		for (int g = 0; g < 4; g++) begin
			chk("run mode", ((g + 1) % 4 == 3) ? 0 : (g + 1) % 4, mode_o[g*2+:2]);
			chk("dac level", g * 12500 + 412500, dac_o[g*20+:20]);
			chk("ref level", g * 12500 + 412500, ref_o[g*20+:20]);
		end
		$display("test ramp done");
		@(posedge clk_i);
		standby <= 1'b1;
		tick(4);
		chk("standby", 4'h1, en_o);
		$display("test standby done");
		// Write while clock enable is low must not land
		@(posedge clk_i);
		ce_i <= 1'b0;
		host.wr(2'h0, 8'h00);
		host.idle();
		@(posedge clk_i);
		ce_i <= 1'b1;
		host.rd(2'h0);
		tick(1);
		chk("frozen ctrl", mdl[0], rd_data);
		chk("frozen enable", 4'h1, en_o);
		$display("test clock enable done");
		conclude();
	end
endmodule : sdr_top_tb
`default_nettype wire

// file: rtl/sdr_channel.sv
`timescale 1ns/1ns
`default_nettype none
`include "sdr_consts.svh"

module sdr_channel #(
	parameter bit INVERT_FREQ = 1'b0
) (
	input wire logic clk_i,
	input wire logic srst_i,
	input wire logic ce_i,
	input wire logic [7:0] ctrl_i,
	input wire logic [4:0] dac_code_i,
	input wire logic en_pin_i,
	input wire logic standby_i,
	input wire logic [19:0] vout_uv_i,
	output logic enabled_o,
	output logic soft_start_o,
	output logic [1:0] mode_o,
	output logic slew_fast_o,
	output logic freq_low_o,
	output logic phase2_o,
	output logic [19:0] dac_uv_o,
	output logic [19:0] ref_uv_o
);
	import sdr_pkg::*;

	localparam logic [29:0] SS_STEP = 30'(`SDR_SS_NV_PER_CYC);
	localparam logic [29:0] SL_STEP = 30'(`SDR_SLEW_NV_PER_CYC);

	sdr_state_t st_q;
	logic req;
	logic [29:0] dac_nv_q, ref_nv_q, tgt_nv;
	logic [1:0] mode_field;

	// ----------------------------------------
	// Enable request
	// ----------------------------------------
	always_comb begin
		req = (ctrl_i[`SDR_BIT_ENABLE] | en_pin_i) &
			(~standby_i | ctrl_i[`SDR_BIT_KEEP_STBY]);
		tgt_nv = 30'(dac_code_i) * 30'(`SDR_DAC_STEP_UV * 1000) +
			30'(`SDR_DAC_BASE_UV * 1000);
		mode_field = ctrl_i[`SDR_MODE_MSB:`SDR_MODE_LSB];
	end

	// ----------------------------------------
	// Start-up sequence
	// ----------------------------------------
	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			st_q <= SDR_ST_OFF;
		end else if (ce_i) begin
			case (st_q)
				SDR_ST_OFF: begin
					if (req) begin
						st_q <= ctrl_i[`SDR_BIT_PREBIAS] ? SDR_ST_WAIT_LOW : SDR_ST_SOFT;
					end
				end
				SDR_ST_WAIT_LOW: begin
					if (!req) begin
						st_q <= SDR_ST_OFF;
					end else if (vout_uv_i < 20'(`SDR_PREBIAS_UV)) begin
						st_q <= SDR_ST_SOFT;
					end
				end
				SDR_ST_SOFT: begin
					if (!req) begin
						st_q <= SDR_ST_OFF;
					end else if (ref_nv_q >= dac_nv_q) begin
						st_q <= SDR_ST_RUN;
					end
				end
				SDR_ST_RUN: begin
					if (!req) begin
						st_q <= SDR_ST_OFF;
					end
				end
				default: st_q <= SDR_ST_OFF;
			endcase
		end
	end

	// ----------------------------------------
	// Slewing DAC output
	// ----------------------------------------
	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			dac_nv_q <= 30'(`SDR_DAC_RESET) * 30'(`SDR_DAC_STEP_UV * 1000) +
				30'(`SDR_DAC_BASE_UV * 1000);
		end else if (ce_i) begin
			if (dac_nv_q + SL_STEP <= tgt_nv) begin
				dac_nv_q <= dac_nv_q + SL_STEP;
			end else if (dac_nv_q >= tgt_nv + SL_STEP) begin
				dac_nv_q <= dac_nv_q - SL_STEP;
			end else begin
				dac_nv_q <= tgt_nv;
			end
		end
	end

	// ----------------------------------------
	// Soft-start reference ramp
	// ----------------------------------------
	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			ref_nv_q <= '0;
		end else if (ce_i) begin
			case (st_q)
				SDR_ST_SOFT: ref_nv_q <= (ref_nv_q + SS_STEP >= dac_nv_q) ?
					dac_nv_q : ref_nv_q + SS_STEP;
				SDR_ST_RUN: ref_nv_q <= dac_nv_q;
				default: ref_nv_q <= '0;
			endcase
		end
	end

	// ----------------------------------------
	// Registered outputs
	// ----------------------------------------
	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			enabled_o <= 1'b0;
			soft_start_o <= 1'b0;
			mode_o <= 2'h0;
			slew_fast_o <= 1'b0;
			freq_low_o <= INVERT_FREQ;
			phase2_o <= 1'b0;
			dac_uv_o <= '0;
			ref_uv_o <= '0;
		end else if (ce_i) begin
			enabled_o <= (st_q == SDR_ST_SOFT) || (st_q == SDR_ST_RUN);
			soft_start_o <= (st_q == SDR_ST_SOFT);
			if (st_q != SDR_ST_RUN || mode_field == SDR_MODE_RSVD) begin
				mode_o <= SDR_MODE_SKIP;
			end else begin
				mode_o <= mode_field;
			end
			slew_fast_o <= ctrl_i[`SDR_BIT_SLEW_FAST];
			freq_low_o <= ctrl_i[`SDR_BIT_FREQ] ^ INVERT_FREQ;
			phase2_o <= ctrl_i[`SDR_BIT_PHASE];
			dac_uv_o <= 20'(dac_nv_q / 30'd1000);
			ref_uv_o <= 20'(ref_nv_q / 30'd1000);
		end
	end

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	property p_pin_enable;
		@(posedge clk_i) disable iff (srst_i)
		(ce_i && st_q == SDR_ST_OFF && en_pin_i && !standby_i && !ctrl_i[4])
			|=> (st_q == SDR_ST_SOFT);
	endproperty
	a_pin_enable: assert property (p_pin_enable) else $error("enable not honoured");

	property p_skip_in_soft;
		@(posedge clk_i) disable iff (srst_i)
		(ce_i && st_q == SDR_ST_SOFT) |=> (mode_o == 2'h0);
	endproperty
	a_skip_in_soft: assert property (p_skip_in_soft) else $error("mode not forced");

	property p_prebias;
		@(posedge clk_i) disable iff (srst_i)
		(ce_i && st_q == SDR_ST_WAIT_LOW && vout_uv_i >= 20'(`SDR_PREBIAS_UV))
			|=> (st_q != SDR_ST_SOFT);
	endproperty
	a_prebias: assert property (p_prebias) else $error("started above limit");

	property p_freq;
		@(posedge clk_i) disable iff (srst_i)
		ce_i |=> (freq_low_o == ($past(ctrl_i[2]) ^ INVERT_FREQ));
	endproperty
	a_freq: assert property (p_freq) else $error("frequency select wrong");

	property p_ramp_bound;
		@(posedge clk_i) disable iff (srst_i)
		(ce_i && st_q == SDR_ST_SOFT) |=> (ref_nv_q <= $past(ref_nv_q) + SS_STEP);
	endproperty
	a_ramp_bound: assert property (p_ramp_bound) else $error("ramp too fast");

	property p_dac_slew;
		@(posedge clk_i) disable iff (srst_i)
		ce_i |=> (dac_nv_q <= $past(dac_nv_q) + SL_STEP) &&
			(dac_nv_q + SL_STEP >= $past(dac_nv_q));
	endproperty
	a_dac_slew: assert property (p_dac_slew) else $error("dac stepped");

	property p_rsvd_mode;
		@(posedge clk_i) disable iff (srst_i)
		(ce_i && mode_field == 2'h3) |=> (mode_o == 2'h0);
	endproperty
	a_rsvd_mode: assert property (p_rsvd_mode) else $error("reserved mode used");

	property p_standby;
		@(posedge clk_i) disable iff (srst_i)
		(ce_i && standby_i && !ctrl_i[1]) |=> (st_q == SDR_ST_OFF);
	endproperty
	a_standby: assert property (p_standby) else $error("standby ignored");
endmodule : sdr_channel

`default_nettype wire

// file: rtl/sdr_consts.svh
`ifndef SDR_CONSTS_SVH
`define SDR_CONSTS_SVH

// ----------------------------------------
// Control register fields
// ----------------------------------------
`define SDR_BIT_SLEW_FAST 0
`define SDR_BIT_KEEP_STBY 1
`define SDR_BIT_FREQ 2
`define SDR_BIT_PHASE 3
`define SDR_BIT_PREBIAS 4
`define SDR_MODE_LSB 5
`define SDR_MODE_MSB 6
`define SDR_BIT_ENABLE 7
`define SDR_CTRL_RESET 8'h00
`define SDR_NUM_REGS 4
`define SDR_REG_A_IDX 2'h0
`define SDR_REG_B_IDX 2'h1
`define SDR_REG_C_IDX 2'h2
`define SDR_REG_D_IDX 2'h3

// ----------------------------------------
// Reference DAC (microvolts)
// ----------------------------------------
`define SDR_DAC_RESET 5'h19
`define SDR_DAC_STEP_UV 12500
`define SDR_DAC_BASE_UV 412500
`define SDR_PREBIAS_UV 300000

// ----------------------------------------
// Timing
// ----------------------------------------
`define SDR_CLK_MHZ 125
`define SDR_SS_UV_PER_MS 800000
`define SDR_SLEW_UV_PER_US 3500
// Per-cycle increments in nanovolts (rounded down)
`define SDR_SS_NV_PER_CYC (`SDR_SS_UV_PER_MS / `SDR_CLK_MHZ)
`define SDR_SLEW_NV_PER_CYC ((`SDR_SLEW_UV_PER_US * 1000) / `SDR_CLK_MHZ)

`endif

// file: rtl/sdr_pkg.sv
package sdr_pkg;
	typedef enum logic [1:0] {
		SDR_MODE_SKIP,
		SDR_MODE_PGROUP,
		SDR_MODE_FCCM,
		SDR_MODE_RSVD
	} sdr_mode_t;
	typedef enum logic [1:0] {
		SDR_ST_OFF,
		SDR_ST_WAIT_LOW,
		SDR_ST_SOFT,
		SDR_ST_RUN
	} sdr_state_t;
endpackage : sdr_pkg

// file: rtl/sdr_top.sv
`timescale 1ns/1ns
`default_nettype none
`include "sdr_consts.svh"

// What this block does
// - A regulator runs when its enable bit is set, else it follows its enable pin.
// - Mode field 00 gives pulse-skipping, 01 pulse-group mode and 10 forced continuous.
// - Bit 0 picks the slow default switch edge or, when set, the fast edge.
// - Bit 1 set keeps the regulator running while the device is in standby.
// - Bit 2 picks 2.25MHz when clear and 1.125MHz when set, per regulator.
// - In the termination variant the first regulator's frequency bit is inverted.
// - Bit 3 picks clock phase 1 when clear and phase 2 when set.
// - Bit 4 set lets the regulator start only while its output is below 300mV.
// - Each reference equals the 5-bit code times 12.5mV plus 412.5mV.
// - The reference code resets to 25, a 725mV reference.
// - Enabling ramps the reference from zero to the DAC output at 0.8V/ms.
// - During the ramp the regulator is held in pulse-skipping whatever the mode field.
// - Every control register field resets to zero.
// - A code change slews the DAC output at 3.5mV/us rather than stepping.

module sdr_top #(
	parameter bit TERMINATION_VARIANT = 1'b0,
	parameter int NUM_CH = `SDR_NUM_REGS
) (
	input wire logic clk_i,
	input wire logic srst_i,
	input wire logic ce_i,
	input wire logic wr_en_i,
	input wire logic [1:0] wr_sel_i,
	input wire logic [7:0] wr_data_i,
	input wire logic [1:0] rd_sel_i,
	output logic [7:0] rd_data_o,
	input wire logic [NUM_CH*5-1:0] reference_dac_code_i,
	input wire logic [NUM_CH-1:0] step_down_enable_pin_i,
	input wire logic standby_i,
	input wire logic [NUM_CH*20-1:0] vout_uv_i,
	output logic [NUM_CH-1:0] enabled_o,
	output logic [NUM_CH-1:0] soft_start_o,
	output logic [NUM_CH*2-1:0] mode_o,
	output logic [NUM_CH-1:0] slew_fast_o,
	output logic [NUM_CH-1:0] freq_low_o,
	output logic [NUM_CH-1:0] phase2_o,
	output logic [NUM_CH*20-1:0] dac_uv_o,
	output logic [NUM_CH*20-1:0] ref_uv_o
);
	import sdr_pkg::*;

	// Index 0..3 = step_down_a..d_control
	logic [7:0] ctrl_q [NUM_CH];

	// ----------------------------------------
	// Command registers
	// ----------------------------------------
	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			for (int i = 0; i < NUM_CH; i++) begin
				ctrl_q[i] <= `SDR_CTRL_RESET;
			end
		end else if (ce_i && wr_en_i) begin
			ctrl_q[wr_sel_i] <= wr_data_i;
		end
	end

	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			rd_data_o <= 8'h00;
		end else if (ce_i) begin
			rd_data_o <= ctrl_q[rd_sel_i];
		end
	end

	// ----------------------------------------
	// Regulator channels
	// ----------------------------------------
	for (genvar g = 0; g < NUM_CH; g++) begin : g_ch
		sdr_channel #(
			.INVERT_FREQ((g == 0) && TERMINATION_VARIANT)
		) u_ch (
			.clk_i(clk_i),
			.srst_i(srst_i),
			.ce_i(ce_i),
			.ctrl_i(ctrl_q[g]),
			.dac_code_i(reference_dac_code_i[g*5 +: 5]),
			.en_pin_i(step_down_enable_pin_i[g]),
			.standby_i(standby_i),
			.vout_uv_i(vout_uv_i[g*20 +: 20]),
			.enabled_o(enabled_o[g]),
			.soft_start_o(soft_start_o[g]),
			.mode_o(mode_o[g*2 +: 2]),
			.slew_fast_o(slew_fast_o[g]),
			.freq_low_o(freq_low_o[g]),
			.phase2_o(phase2_o[g]),
			.dac_uv_o(dac_uv_o[g*20 +: 20]),
			.ref_uv_o(ref_uv_o[g*20 +: 20])
		);
	end

	property p_reg_write;
		@(posedge clk_i) disable iff (srst_i)
		(ce_i && wr_en_i) |=> (ctrl_q[$past(wr_sel_i)] == $past(wr_data_i));
	endproperty
	a_reg_write: assert property (p_reg_write) else $error("register write lost");
endmodule : sdr_top

`default_nettype wire
